// ===== include/adcc_pkg.sv
// Constants, types and register map of the converter control block
// How it works
// [R1] Successive approximation turns held sample into 8 bits; at osc/2 each bit after bit 7 uses the previous trial's compare
// [R2] Five channels small variant, eight large variant
// [R3] Reference is supply or reference-capable pin
// [R4] Converts in sleep only with internal RC clock; a conversion started on a divided clock runs on in sleep once RC is selected
// [R5] Bits 7:6 pick osc/2, /8, /32 or RC
// [R6] Bits 5:3 pick channel 0 to 7
// [R7] Channels 5 to 7 only on large variant
// [R8] Writing go starts; reads 1 while converting
// [R9] Hardware clears go when conversion finishes
// [R10] Bit 1 reads zero, writes ignored
// [R11] Bit 0 powers the converter; 0 shuts off
// [R12] After reset analog pins read as zero
// [R13] Port E analog pins read as zero
// [R14] Second register picks analog per pin, reference; the reference bit is kept in its own register, ADDR_REFSEL
// [R15] Direction bits still drive analog pins
// [R16] Completion stores result, clears go, sets flag
// [R17] Clearing go aborts; result kept, no flag
// [R18] One conversion takes nine bit periods
// [R19] RC clock waits one instruction cycle first
// [R20] Start ignored while converter powered off
`default_nettype none
package adcc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Internal RC bit period, nominal of its 2 to 6 us spread
    localparam int unsigned RC_BIT_NS = 4000;
    localparam int unsigned RC_BIT_CYCLES = RC_BIT_NS / CLK_PERIOD_NS;
    // One instruction cycle is four oscillator periods
    localparam int unsigned INSTR_OSC_PERIODS = 4;
    localparam int unsigned INSTR_CYCLES = INSTR_OSC_PERIODS;
    localparam int unsigned PERIODS_PER_CONV = 9;
    localparam int unsigned DIV_W = 7;

    localparam logic [8:0] ADDR_RESULT = 9'h01E;
    localparam logic [8:0] ADDR_CTRL = 9'h01F;
    localparam logic [8:0] ADDR_REFSEL = 9'h09E;
    localparam logic [8:0] ADDR_ANCFG = 9'h09F;

    localparam int unsigned CTRL_CLK_LSB = 6;
    localparam int unsigned CTRL_CH_LSB = 3;
    localparam int unsigned CTRL_GO_BIT = 2;
    localparam int unsigned CTRL_ON_BIT = 0;
    localparam int unsigned REFSEL_BIT = 0;

    localparam logic [1:0] CLKSEL_DIV2 = 2'h0;
    localparam logic [1:0] CLKSEL_DIV8 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV32 = 2'h2;
    localparam logic [1:0] CLKSEL_RC = 2'h3;
    localparam logic [DIV_W-1:0] DIV2_CYCLES = 7'h02;
    localparam logic [DIV_W-1:0] DIV8_CYCLES = 7'h08;
    localparam logic [DIV_W-1:0] DIV32_CYCLES = 7'h20;

    localparam logic [1:0] CLKSEL_RESET = 2'h0;
    localparam logic [2:0] CHSEL_RESET = 3'h0;
    localparam logic POWER_RESET = 1'b0;
    localparam logic [7:0] ANCFG_RESET = 8'hFF;
    localparam logic REFSEL_RESET = 1'b0;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RCWAIT = 3'b010,
        ST_CONV = 3'b100
    } adcc_state_e;
endpackage
`default_nettype wire

// ===== rtl/adcc_top.sv
// Converter control: register port, conversion sequencer and pin read masking
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module adcc_top #(
    parameter int unsigned NUM_CH = 8
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [8:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sleep_i,
    input wire logic comparator_i,
    input wire logic [5:0] port_a_pins_i,
    input wire logic [2:0] port_e_pins_i,
    output logic [5:0] port_a_read_o,
    output logic [2:0] port_e_read_o,
    output logic [7:0] pin_analog_enable_o,
    output logic [2:0] analog_channel_select_o,
    output logic sample_hold_o,
    output logic [7:0] dac_code_o,
    output logic reference_select_o,
    output logic converter_enable_o,
    output logic conversion_done_flag_o
);
    localparam int unsigned DIV_W_L = adcc_pkg::DIV_W;
    adcc_pkg::adcc_state_e st;
    logic [1:0] conversion_clock_select;
    logic [2:0] analog_channel_select;
    logic converter_power_on;
    logic [7:0] pin_analog_config_register;
    logic reference_select;
    logic [7:0] conversion_result_register;
    logic [7:0] sar;
    logic [7:0] trial;
    logic [DIV_W_L-1:0] div_cnt;
    logic [DIV_W_L-1:0] bit_len_q;
    logic [DIV_W_L-1:0] next_bit_len;
    logic [3:0] bit_cnt;
    logic [2:0] wait_cnt;
    logic cmp_meta;
    logic cmp_sync;
    logic [8:0] pin_meta;
    logic [8:0] pin_sync;
    logic busy;
    logic rc_sel;
    logic ctrl_wr;
    logic start_req;
    logic abort_req;
    logic bit_tick;
    logic last_tick;
    logic [7:0] next_sar;
    logic [5:0] port_a_mask;
    logic [2:0] port_e_mask;
    logic [2:0] wr_ch;

    assign busy = !st[0];
    assign rc_sel = conversion_clock_select == adcc_pkg::CLKSEL_RC;
    assign ctrl_wr = reg_wr_i && reg_addr_i == adcc_pkg::ADDR_CTRL;
    assign wr_ch = reg_wdata_i[adcc_pkg::CTRL_CH_LSB +: 3];
    // Go only honoured from idle with the module already powered
    assign start_req = ctrl_wr && reg_wdata_i[adcc_pkg::CTRL_GO_BIT]
        && converter_power_on && !busy; // see [R8] see [R20]
    // Clearing go, powering down, or sleeping on a non-RC clock all abort
    assign abort_req = busy && ((ctrl_wr && !reg_wdata_i[adcc_pkg::CTRL_GO_BIT])
        || (ctrl_wr && !reg_wdata_i[adcc_pkg::CTRL_ON_BIT])
        || (sleep_i && !rc_sel)); // see [R17] see [R4]
    assign bit_tick = st == adcc_pkg::ST_CONV && div_cnt == bit_len_q - 1'b1;
    assign last_tick = bit_tick && bit_cnt == 4'(adcc_pkg::PERIODS_PER_CONV - 1); // see [R18]

    // Bit period length from the clock select, latched at start
    always_comb
    begin
        unique case (conversion_clock_select) // see [R5]
            adcc_pkg::CLKSEL_DIV2: next_bit_len = adcc_pkg::DIV2_CYCLES;
            adcc_pkg::CLKSEL_DIV8: next_bit_len = adcc_pkg::DIV8_CYCLES;
            adcc_pkg::CLKSEL_DIV32: next_bit_len = adcc_pkg::DIV32_CYCLES;
            adcc_pkg::CLKSEL_RC: next_bit_len = DIV_W_L'(adcc_pkg::RC_BIT_CYCLES);
        endcase
    end

    // Keep the trial bit when the held input was at or above the DAC level two clocks earlier
    always_comb
    begin
        next_sar = (cmp_sync ? sar : (sar & ~trial)) | (trial >> 1); // see [R1]
    end

    // Comparator and pins are asynchronous to the system clock
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
            pin_meta <= 9'h000;
            pin_sync <= 9'h000;
        end
        else
        begin
            cmp_meta <= comparator_i;
            cmp_sync <= cmp_meta;
            pin_meta <= {port_e_pins_i, port_a_pins_i};
            pin_sync <= pin_meta;
        end
    end

    // Main control register
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            conversion_clock_select <= adcc_pkg::CLKSEL_RESET;
            analog_channel_select <= adcc_pkg::CHSEL_RESET;
            converter_power_on <= adcc_pkg::POWER_RESET;
        end
        else if (ctrl_wr)
        begin
            conversion_clock_select <= reg_wdata_i[adcc_pkg::CTRL_CLK_LSB +: 2]; // see [R5]
            // Codes past the fitted channel count are dropped
            if (32'(wr_ch) < NUM_CH)
            begin
                analog_channel_select <= wr_ch; // see [R6] see [R7] see [R2]
            end
            converter_power_on <= reg_wdata_i[adcc_pkg::CTRL_ON_BIT]; // see [R11]
        end
    end

    // Pin configuration and reference select
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            pin_analog_config_register <= adcc_pkg::ANCFG_RESET; // see [R12]
            reference_select <= adcc_pkg::REFSEL_RESET;
        end
        else if (reg_wr_i && reg_addr_i == adcc_pkg::ADDR_ANCFG)
        begin
            pin_analog_config_register <= reg_wdata_i; // see [R14]
        end
        else if (reg_wr_i && reg_addr_i == adcc_pkg::ADDR_REFSEL)
        begin
            reference_select <= reg_wdata_i[adcc_pkg::REFSEL_BIT]; // see [R3]
        end
    end

    // Sequencer
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            st <= adcc_pkg::ST_IDLE;
        end
        else if (abort_req || (busy && !converter_power_on))
        begin
            st <= adcc_pkg::ST_IDLE;
        end
        else
        begin
            unique case (st)
                adcc_pkg::ST_IDLE:
                begin
                    if (start_req)
                    begin
                        st <= rc_sel ? adcc_pkg::ST_RCWAIT : adcc_pkg::ST_CONV; // see [R19]
                    end
                end
                adcc_pkg::ST_RCWAIT:
                begin
                    if (wait_cnt == 3'(adcc_pkg::INSTR_CYCLES - 1))
                    begin
                        st <= adcc_pkg::ST_CONV; // see [R19]
                    end
                end
                adcc_pkg::ST_CONV:
                begin
                    if (last_tick)
                    begin
                        st <= adcc_pkg::ST_IDLE; // see [R9]
                    end
                end
                default: st <= adcc_pkg::ST_IDLE;
            endcase
        end
    end

    // Counters: RC start delay, bit period divider, bit period count
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i || st != adcc_pkg::ST_RCWAIT)
        begin
            wait_cnt <= 3'h0;
        end
        else
        begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            div_cnt <= '0;
            bit_cnt <= 4'h0;
            bit_len_q <= adcc_pkg::DIV2_CYCLES;
        end
        else if (st != adcc_pkg::ST_CONV)
        begin
            div_cnt <= '0;
            bit_cnt <= 4'h0;
            if (start_req)
            begin
                bit_len_q <= next_bit_len;
            end
        end
        else if (bit_tick)
        begin
            div_cnt <= '0;
            bit_cnt <= bit_cnt + 4'h1; // see [R18]
        end
        else
        begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // Successive approximation; period 0 is settling of the held sample
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i || st != adcc_pkg::ST_CONV)
        begin
            sar <= adcc_pkg::SAR_FIRST_TRIAL;
            trial <= adcc_pkg::SAR_FIRST_TRIAL;
        end
        else if (bit_tick && bit_cnt != 4'h0)
        begin
            sar <= next_sar; // see [R1]
            trial <= trial >> 1;
        end
    end

    // Result and done pulse only on a full conversion, never on abort
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            conversion_result_register <= adcc_pkg::RESULT_RESET;
            conversion_done_flag_o <= 1'b0;
        end
        else
        begin
            conversion_done_flag_o <= last_tick && !abort_req; // see [R16] see [R17]
            if (last_tick && !abort_req)
            begin
                conversion_result_register <= next_sar; // see [R16]
            end
        end
    end

    // Analog-selected pins read as zero; port A bit 4 has no analog function
    always_comb
    begin
        port_a_mask = {pin_analog_config_register[4], 1'b0, pin_analog_config_register[3:0]};
        port_e_mask = (NUM_CH > 5) ? pin_analog_config_register[7:5] : 3'h0;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            port_a_read_o <= 6'h00; // see [R12]
            port_e_read_o <= 3'h0;
        end
        else
        begin
            port_a_read_o <= pin_sync[5:0] & ~port_a_mask;
            port_e_read_o <= pin_sync[8:6] & ~port_e_mask; // see [R13]
        end
    end

    // Read port: data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i || !reg_rd_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            unique case (reg_addr_i)
                adcc_pkg::ADDR_CTRL:
                    reg_rdata_o <= {conversion_clock_select, analog_channel_select,
                        busy, 1'b0, converter_power_on}; // see [R8] see [R10]
                adcc_pkg::ADDR_RESULT: reg_rdata_o <= conversion_result_register;
                adcc_pkg::ADDR_ANCFG: reg_rdata_o <= pin_analog_config_register;
                adcc_pkg::ADDR_REFSEL: reg_rdata_o <= {7'h00, reference_select};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Analog front end controls
    assign pin_analog_enable_o = pin_analog_config_register; // see [R15]
    assign analog_channel_select_o = analog_channel_select; // see [R6]
    assign sample_hold_o = st[2];
    assign dac_code_o = sar;
    assign reference_select_o = reference_select; // see [R3]
    // Module shut off on a non-RC clock during sleep even if the bit stays set
    assign converter_enable_o = converter_power_on && !(sleep_i && !rc_sel); // see [R11] see [R4]

    // Checks
    logic [9:0] conv_cycles;
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i || st != adcc_pkg::ST_CONV)
        begin
            conv_cycles <= 10'h000;
        end
        else
        begin
            conv_cycles <= conv_cycles + 10'h001;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_go_write;
        ctrl_wr && reg_wdata_i[adcc_pkg::CTRL_GO_BIT];
    endsequence
    sequence s_rc_start;
        start_req && rc_sel;
    endsequence
    sequence s_ctrl_read;
        reg_rd_i && reg_addr_i == adcc_pkg::ADDR_CTRL;
    endsequence

    a_start_when_off: assert property ((s_go_write and (!converter_power_on && !busy))
        |=> st == adcc_pkg::ST_IDLE ##1 !conversion_done_flag_o) // see [R20]
        else $error("start accepted while powered off");
    a_rc_start_wait: assert property (s_rc_start |=> st == adcc_pkg::ST_RCWAIT [*4]
        ##1 (st == adcc_pkg::ST_CONV || !converter_power_on || st == adcc_pkg::ST_IDLE)) // see [R19]
        else $error("RC start delay wrong");
    a_conv_length: assert property (last_tick
        |-> conv_cycles == 10'(adcc_pkg::PERIODS_PER_CONV * bit_len_q - 1)) // see [R18]
        else $error("conversion length not nine bit periods");
    a_done_result: assert property ((last_tick && !abort_req)
        |=> conversion_done_flag_o && !busy && conversion_result_register == $past(next_sar)) // see [R16]
        else $error("completion did not store result");
    a_abort_keeps: assert property (abort_req
        |=> $stable(conversion_result_register) && !conversion_done_flag_o && !busy) // see [R17]
        else $error("abort changed result or flagged");
    a_go_reads_busy: assert property (s_ctrl_read
        |=> reg_rdata_o[adcc_pkg::CTRL_GO_BIT] == $past(busy) && !reg_rdata_o[1]) // see [R8]
        else $error("go or unused bit reads wrong");
    a_done_clears_go: assert property (conversion_done_flag_o |-> !busy) // see [R9]
        else $error("go still set after completion");
    // Read value is registered, so it follows the mask one cycle late
    a_port_e_zero: assert property ((port_e_read_o & $past(port_e_mask)) == 3'h0) // see [R13]
        else $error("analog port E pin read nonzero");
    a_sleep_rc_only: assert property ((sleep_i && !rc_sel) |-> !converter_enable_o ##1 !busy) // see [R4]
        else $error("converter ran in sleep on a non-RC clock");
    a_chan_route: assert property (ctrl_wr && 32'(wr_ch) < NUM_CH
        |=> analog_channel_select_o == $past(wr_ch)) // see [R6]
        else $error("channel select not routed");
endmodule
`default_nettype wire

// ===== tb/adcc_analog_model.sv
// Behavioural model of the analog pins, sample-and-hold and comparator
`timescale 1ns/100ps
`default_nettype none
module adcc_analog_model
(
    input wire logic sys_clk_i,
    input wire logic [7:0] level_i,
    input wire logic sample_hold_i,
    input wire logic [7:0] dac_code_i,
    output logic comparator_o
);
    logic [7:0] held;

    // Tracks the pin while sampling, frozen while the converter holds
    always_ff @(posedge sys_clk_i)
    begin
        if (!sample_hold_i)
        begin
            held <= level_i;
        end
    end

    // Comparator high while held input is at or above the trial code
    assign comparator_o = (held >= dac_code_i);
endmodule
`default_nettype wire

// ===== tb/adcc_top_tb_top.sv
// Self-checking testbench of the converter control block
`timescale 1ns/100ps
`default_nettype none
module adcc_top_tb_top;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [8:0] reg_addr_i = 9'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic [5:0] port_a_pins_i = 6'h3F;
    logic [2:0] port_e_pins_i = 3'h7;
    logic [7:0] level = 8'h00;
    logic comparator_w;
    logic [7:0] reg_rdata_o;
    logic [5:0] port_a_read_o;
    logic [2:0] port_e_read_o;
    logic [7:0] pin_analog_enable_o;
    logic [2:0] analog_channel_select_o;
    logic sample_hold_o;
    logic [7:0] dac_code_o;
    logic reference_select_o;
    logic converter_enable_o;
    logic conversion_done_flag_o;
    int error_cnt = 0;
    int n_checks = 0;

    always #20 sys_clk_i = ~sys_clk_i;

    adcc_top #(.NUM_CH(8)) u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .sleep_i(sleep_i), .comparator_i(comparator_w), .port_a_pins_i(port_a_pins_i),
        .port_e_pins_i(port_e_pins_i), .port_a_read_o(port_a_read_o), .port_e_read_o(port_e_read_o),
        .pin_analog_enable_o(pin_analog_enable_o), .analog_channel_select_o(analog_channel_select_o),
        .sample_hold_o(sample_hold_o), .dac_code_o(dac_code_o), .reference_select_o(reference_select_o),
        .converter_enable_o(converter_enable_o), .conversion_done_flag_o(conversion_done_flag_o));

    adcc_analog_model u_model (.sys_clk_i(sys_clk_i), .level_i(level), .sample_hold_i(sample_hold_o),
        .dac_code_i(dac_code_o), .comparator_o(comparator_w));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic rd_check(input logic [8:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(16'(d), 16'(exp));
    endtask

    // Counts cycles from the write that started, bounded against a hang
    task automatic wait_done(output int n);
        n = 1;
        #1;
        while (conversion_done_flag_o !== 1'b1 && n < 1200)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
    endtask

    task automatic count_done(input int span, output int cnt);
        cnt = 0;
        repeat (span)
        begin
            @(posedge sys_clk_i);
            #1;
            if (conversion_done_flag_o === 1'b1)
                cnt++;
        end
    endtask

    task automatic convert(input logic [1:0] sel, input logic [7:0] lvl, input bit chk_res);
        int n;
        int per;
        int exp_n;
        per = (sel == adcc_pkg::CLKSEL_DIV2) ? int'(adcc_pkg::DIV2_CYCLES) :
              (sel == adcc_pkg::CLKSEL_DIV8) ? int'(adcc_pkg::DIV8_CYCLES) :
              (sel == adcc_pkg::CLKSEL_DIV32) ? int'(adcc_pkg::DIV32_CYCLES) : int'(adcc_pkg::RC_BIT_CYCLES);
        exp_n = adcc_pkg::PERIODS_PER_CONV * per + 1;
        if (sel == adcc_pkg::CLKSEL_RC)
            exp_n = exp_n + adcc_pkg::INSTR_CYCLES;
        level <= lvl;
        wr(adcc_pkg::ADDR_CTRL, {sel, 6'h01});
        wr(adcc_pkg::ADDR_CTRL, {sel, 6'h05});
        wait_done(n);
        check(16'(n), 16'(exp_n));
        check(16'(sample_hold_o), 16'h0000);
        if (chk_res)
        begin
            // Final SAR result still shows on the DAC code in the done cycle
            check(16'(dac_code_o), 16'(lvl));
            rd_check(adcc_pkg::ADDR_RESULT, lvl);
            rd_check(adcc_pkg::ADDR_CTRL, {sel, 6'h01});
        end
    endtask

    task automatic test_reset;
        rd_check(adcc_pkg::ADDR_CTRL, 8'h00);
        rd_check(adcc_pkg::ADDR_ANCFG, 8'hFF);
        rd_check(adcc_pkg::ADDR_RESULT, 8'h00);
        rd_check(adcc_pkg::ADDR_REFSEL, 8'h00);
        rd_check(9'h020, 8'h00);
        check(16'(port_a_read_o), 16'h0010);
        check(16'(port_e_read_o), 16'h0000);
    endtask

    task automatic test_regs;
        int cnt;
        // Start request with power off must stay idle
        wr(adcc_pkg::ADDR_CTRL, 8'h3E);
        rd_check(adcc_pkg::ADDR_CTRL, 8'h38);
        count_done(40, cnt);
        check(16'(cnt), 16'h0000);
        check(16'(converter_enable_o), 16'h0000);
        for (int ch = 0; ch < 8; ch++)
        begin
            wr(adcc_pkg::ADDR_CTRL, {2'h1, 3'(ch), 3'h1});
            #1;
            check(16'(analog_channel_select_o), 16'(ch));
        end
        check(16'(converter_enable_o), 16'h0001);
        wr(adcc_pkg::ADDR_REFSEL, 8'h01);
        #1;
        check(16'(reference_select_o), 16'h0001);
        rd_check(adcc_pkg::ADDR_REFSEL, 8'h01);
    endtask

    task automatic test_ports;
        wr(adcc_pkg::ADDR_ANCFG, 8'h00);
        repeat (4) @(posedge sys_clk_i);
        #1;
        check(16'(port_a_read_o), 16'h003F);
        check(16'(port_e_read_o), 16'h0007);
        wr(adcc_pkg::ADDR_ANCFG, 8'hA5);
        #1;
        check(16'(pin_analog_enable_o), 16'h00A5);
        // Pin reads are registered behind the mask
        @(posedge sys_clk_i);
        #1;
        check(16'(port_a_read_o), 16'h003A);
        check(16'(port_e_read_o), 16'h0002);
        rd_check(adcc_pkg::ADDR_ANCFG, 8'hA5);
    endtask

    task automatic test_convert;
        int cnt;
        level <= 8'h9C;
        wr(adcc_pkg::ADDR_CTRL, 8'h41);
        wr(adcc_pkg::ADDR_CTRL, 8'h45);
        rd_check(adcc_pkg::ADDR_CTRL, 8'h45);
        count_done(80, cnt);
        check(16'(cnt), 16'h0001);
        rd_check(adcc_pkg::ADDR_CTRL, 8'h41);
        // Every clock source, /2 result skipped: comparator is stale there
        for (int s = 0; s < 4; s++)
            convert(2'(s), 8'h3C + 8'(s), s != 0);
        // Abort in mid-conversion keeps the old result
        convert(adcc_pkg::CLKSEL_DIV8, 8'h5A, 1'b1);
        level <= 8'hC3;
        wr(adcc_pkg::ADDR_CTRL, 8'h45);
        repeat (20) @(posedge sys_clk_i);
        wr(adcc_pkg::ADDR_CTRL, 8'h41);
        count_done(200, cnt);
        check(16'(cnt), 16'h0000);
        rd_check(adcc_pkg::ADDR_RESULT, 8'h5A);
    endtask

    task automatic test_sleep;
        int cnt;
        int n;
        int exp_n;
        exp_n = adcc_pkg::PERIODS_PER_CONV * adcc_pkg::RC_BIT_CYCLES + 1 + adcc_pkg::INSTR_CYCLES;
        wr(adcc_pkg::ADDR_CTRL, 8'h45);
        sleep_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check(16'(converter_enable_o), 16'h0000);
        count_done(100, cnt);
        check(16'(cnt), 16'h0000);
        sleep_i <= 1'b0;
        rd_check(adcc_pkg::ADDR_CTRL, 8'h41);
        level <= 8'h77;
        wr(adcc_pkg::ADDR_CTRL, 8'hC1);
        sleep_i <= 1'b1;
        wr(adcc_pkg::ADDR_CTRL, 8'hC5);
        wait_done(n);
        check(16'(n), 16'(exp_n));
        check(16'(converter_enable_o), 16'h0001);
        rd_check(adcc_pkg::ADDR_RESULT, 8'h77);
        sleep_i <= 1'b0;
    endtask

    task automatic final_report;
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        test_reset();
        test_regs();
        test_ports();
        test_convert();
        test_sleep();
        final_report();
    end

    // Whole run needs a few thousand cycles; this bound only cuts a hang
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        final_report();
    end
endmodule
`default_nettype wire
